// ### bench/rbspc_jtag_emu.sv
// Partner: emulator pod driving the test reset and scan select pins
`timescale 1ns/1ns
module rbspc_jtag_emu
(
  input  logic i_clk_sys,
  output logic o_test_rst_n,
  output logic o_scan_sel_lo,
  output logic o_scan_sel_hi
);
  initial
  begin
    o_test_rst_n = 1'b1;
    {o_scan_sel_lo, o_scan_sel_hi} = 2'b00;
  end
  // Pins held well past the rise: the capture sees them only after synchronising
  task automatic pick(input logic [1:0] m);
    @(negedge i_clk_sys);
    {o_scan_sel_lo, o_scan_sel_hi} = m;
    o_test_rst_n = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    o_test_rst_n = 1'b1;
    repeat (6) @(negedge i_clk_sys);
  endtask
endmodule

// ### bench/rbspc_monitor.sv
// Checker: port-level timing properties of the reset, strap and power control block
`timescale 1ns/1ns
module rbspc_monitor
  import rbspc_pkg::*;
#(
  parameter int NUM_PERIPH = 16
)
(
  input logic                         i_clk_sys,
  input logic                         i_rst_n,
  input logic                         i_mcu_sel,
  input logic                         i_mcu_we,
  input logic [31:0]                  i_mcu_addr,
  input logic                         i_wdog_rst_cmd,
  input logic [NUM_PERIPH-1:0]        i_periph_irq,
  input rbspc_pkg::rbspc_clk_mode_t   i_pll_mode_cfg,
  input logic [9:0]                   i_pd_divisor,
  input logic [15:0]                  i_dsp_prog_addr,
  input logic                         o_mcu_ack,
  input logic [31:0]                  o_mcu_rdata,
  input logic                         o_mcu_rst_n,
  input logic [NUM_PERIPH-1:0]        o_periph_rst_n,
  input logic [31:0]                  o_mcu_reset_vector,
  input logic [15:0]                  o_dsp_reset_vector,
  input rbspc_pkg::rbspc_scan_mode_t  o_scan_mode,
  input logic [4:0]                   o_ir_len_total,
  input logic                         o_mcu_clk_tick,
  input logic                         o_overlay_hit,
  input logic                         o_overlay_en,
  input logic [15:0]                  o_overlay_data_addr,
  input rbspc_pkg::rbspc_boot_mem_t   o_dsp_boot_mem,
  input logic                         o_instr_32bit,
  input logic                         o_big_endian,
  input logic                         o_mcu_run
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------------------------------------
  // Named steps
  // ----------------------------------------------------------------------
  // Two cycles of a stopping divisor, so the registered tick has caught up
  sequence s_pd_low;
    (i_pll_mode_cfg == CLK_PDOWN && i_pd_divisor < PD_DIV_MIN) [*2];
  endsequence
  sequence s_rd_unmapped;
    i_mcu_sel && !i_mcu_we && i_mcu_addr != RST_CTRL_ADDR;
  endsequence
  // Properties
  AST_ACK: assert property (i_mcu_sel |=> o_mcu_ack)
    else $error("access not acknowledged");
  AST_RDZ: assert property (s_rd_unmapped |=> o_mcu_rdata == RDATA_NONE)
    else $error("unmapped read not zero");
  AST_WDOG: assert property (i_wdog_rst_cmd |=> !o_mcu_rst_n [*5])
    else $error("watchdog stretch too short");
  AST_VEC: assert property (o_mcu_reset_vector == 32'h0 && o_dsp_reset_vector == 16'hFF80)
    else $error("reset vector wrong");
  AST_PRST: assert property (!o_mcu_rst_n |-> o_periph_rst_n == '0)
    else $error("peripheral not reset with core");
  AST_CHAIN: assert property (o_scan_mode == SCAN_CHAIN |-> o_ir_len_total == 5'h14)
    else $error("chain length wrong");
  AST_PDSTOP: assert property (s_pd_low |-> !o_mcu_clk_tick)
    else $error("tick with small divisor");
  AST_OVL: assert property (o_overlay_hit |-> o_overlay_en && o_overlay_data_addr == i_dsp_prog_addr - 16'hC000)
    else $error("overlay mapping wrong");
  AST_EXT: assert property (o_dsp_boot_mem == BOOT_EXTERNAL |-> !o_overlay_en)
    else $error("external boot with overlay");
  AST_WAKE: assert property (|i_periph_irq |=> o_mcu_run)
    else $error("interrupt did not wake core");
  AST_STRAP: assert property (i_rst_n [*5] |=> $stable(o_instr_32bit) && $stable(o_big_endian))
    else $error("strap changed after capture");
endmodule

// ### bench/rbspc_top_tb.sv
// Testbench: reset routing, straps, boot, scan and clock control of rbspc_top
`timescale 1ns/1ns
module rbspc_top_tb;
  import rbspc_pkg::*;
  logic i_clk_sys, i_rst_n, i_test_rst_n, i_instr_width_strap, i_endian_strap, i_scan_sel_lo, i_scan_sel_hi;
  logic i_wdog_rst_cmd, i_mcu_sel, i_mcu_we, i_dsp_cfg_wr, i_periph_rst_wr, i_clk_stop_wr, i_wake_wr;
  logic o_mcu_ack, o_mcu_rst_n, o_dsp_rst_n, o_ext_rst_n, o_boot_chip_select, o_instr_32bit, o_big_endian;
  logic o_overlay_en, o_overlay_hit, o_mcu_clk_tick, o_mcu_run;
  logic [31:0] i_mcu_addr, i_mcu_wdata, o_mcu_rdata, o_mcu_reset_vector, rd, s, seed;
  logic [15:0] i_dsp_cfg_data, i_dsp_prog_addr, o_dsp_reset_vector, o_overlay_data_addr;
  logic [15:0] i_periph_rst_data, i_periph_irq, o_periph_rst_n, o_periph_run;
  logic [16:0] i_clk_stop_data, i_wake_data;
  logic [13:0] o_dsp_pll_default, o_mcu_pll_default;
  logic [4:0]  o_ir_len_mcu, o_ir_len_dsp, o_ir_len_chip, o_ir_len_total;
  logic [1:0]  i_div_ratio, st;
  logic [9:0]  i_pd_divisor;
  rbspc_clk_mode_t  i_pll_mode_cfg;
  rbspc_scan_mode_t o_scan_mode;
  rbspc_boot_mem_t  o_dsp_boot_mem;
  int n_mismatch, total_checks, k, c;
  rbspc_top #(.MCU_PLL_DEFAULT(14'h2A5)) i_rbspc_top (.*);
  rbspc_jtag_emu i_rbspc_jtag_emu (.i_clk_sys, .o_test_rst_n(i_test_rst_n), .o_scan_sel_lo(i_scan_sel_lo),
    .o_scan_sel_hi(i_scan_sel_hi));
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic rbspc_boot_mem_t exp_boot(input logic [1:0] b);
    return (b == 2'b11) ? BOOT_EXTERNAL : (b == 2'b01) ? BOOT_PROG_RAM : BOOT_SHADOW_RAM;
  endfunction
  function automatic logic [4:0] exp_len(input logic [1:0] m);
    return (m == 2'b00) ? 5'h04 : (m == 2'b01) ? 5'h08 : (m == 2'b11) ? 5'h14 : 5'h00;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(negedge i_clk_sys);
  endtask
  // One access; answer sampled one cycle after the take
  task automatic bus(input logic we, input logic [31:0] a, input logic [31:0] d);
    {i_mcu_sel, i_mcu_we, i_mcu_addr, i_mcu_wdata} = {1'b1, we, a, d};
    step();
    i_mcu_sel = 1'b0;
    rd = o_mcu_rdata;
    chk(o_mcu_ack, 1);
    step(); // Idle cycle, so a next call never re-raises select in the same step
  endtask
  task automatic ticks(input int settle, input int n, input int exp);
    repeat (settle) step();
    c = 0;
    repeat (n)
    begin
      step();
      if (o_mcu_clk_tick === 1'b1) c++;
    end
    chk(c, exp);
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  // Hang guard
  initial
  begin
    #1000000;
    n_mismatch++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    seed = 32'hEFD6;
    {i_rst_n, i_wdog_rst_cmd, i_mcu_sel, i_mcu_we, i_dsp_cfg_wr, i_periph_rst_wr, i_clk_stop_wr, i_wake_wr} = '0;
    {i_mcu_addr, i_mcu_wdata, i_dsp_cfg_data, i_dsp_prog_addr, i_periph_rst_data, i_periph_irq} = '0;
    {i_clk_stop_data, i_wake_data, i_div_ratio, i_pd_divisor} = '0;
    i_pll_mode_cfg = CLK_PLL;
    for (k = 0; k < 2; k++)
    begin
      s = rnd();
      st = s[1:0];
      i_rst_n = 1'b0;
      {i_instr_width_strap, i_endian_strap} = st;
      repeat (4) step();
      chk({o_mcu_rst_n, o_dsp_rst_n, o_ext_rst_n}, 0);
      i_rst_n = 1'b1;
      step();
      chk({o_mcu_rst_n, o_dsp_rst_n, o_ext_rst_n}, 3'b101);
      repeat (4) step();
      chk({o_instr_32bit, o_big_endian}, st);
    end
    // Every boot bit pair, random PLL field
    for (k = 0; k < 5; k++)
    begin
      s = rnd();
      i_dsp_cfg_data = {k[1:0] & {2{k < 4}}, s[13:0]};
      i_dsp_cfg_wr = 1'b1;
      step();
      chk(o_dsp_boot_mem, exp_boot(i_dsp_cfg_data[15:14]));
      chk(o_overlay_en, !i_dsp_cfg_data[14]);
      chk(o_dsp_pll_default, s[13:0]);
    end
    i_dsp_cfg_wr = 1'b0;
    chk(o_mcu_pll_default, 14'h2A5);
    i_dsp_prog_addr = 16'hF900;
    step();
    chk({o_overlay_hit, o_overlay_data_addr}, 17'h13900);
    i_dsp_prog_addr = 16'hF7FF;
    step();
    chk(o_overlay_hit, 0);
    chk({o_mcu_reset_vector, o_dsp_reset_vector, o_boot_chip_select}, {32'h0, 16'hFF80, 1'b1});
    bus(0, RST_CTRL_ADDR, 0);
    chk(rd, 32'h1);
    bus(1, RST_CTRL_ADDR + 32'h4, 0);
    bus(0, rnd() | 32'h1, 0);
    chk({rd, o_dsp_rst_n}, 0);
    // Boot memory chosen above, so the core may now be let go
    bus(1, RST_CTRL_ADDR, 32'h2);
    step();
    chk({o_mcu_rst_n, o_dsp_rst_n, o_ext_rst_n}, 3'b110);
    bus(1, RST_CTRL_ADDR, 0);
    step();
    chk({o_mcu_rst_n, o_dsp_rst_n, o_ext_rst_n}, 3'b111);
    {i_periph_rst_wr, i_periph_rst_data} = {1'b1, 16'h0};
    step();
    i_periph_rst_wr = 1'b0;
    chk(o_periph_rst_n, 0);
    i_wdog_rst_cmd = 1'b1;
    c = 0;
    repeat (20)
    begin
      step();
      i_wdog_rst_cmd = 1'b0;
      c += (o_mcu_rst_n === 1'b0) + 100 * (o_dsp_rst_n !== 1'b1 || o_ext_rst_n !== 1'b1);
    end
    chk(c, WDOG_RST_CYCLES + 1);
    chk(o_periph_rst_n, 16'hFFFF);
    ticks(2, 4, 4);
    {i_pll_mode_cfg, i_div_ratio} = {CLK_DIV, 2'h1};
    ticks(4, 8, 4);
    for (k = 0; k < 3; k++)
    begin
      s = rnd();
      i_pd_divisor = (k == 0) ? PD_DIV_MIN : (k == 1) ? 10'h3FF : {1'b1, s[8:0]};
      i_pll_mode_cfg = CLK_PDOWN;
      ticks(i_pd_divisor + 4, 2 * i_pd_divisor, 2);
    end
    i_pd_divisor = PD_DIV_MIN - 10'h1;
    ticks(2, 600, 0);
    i_pll_mode_cfg = CLK_RSVD;
    ticks(2, 20, 0);
    i_pll_mode_cfg = CLK_DIV;
    s = rnd();
    {i_clk_stop_wr, i_clk_stop_data} = {1'b1, 17'h1 | (17'h2 << s[3:0])};
    step();
    {i_clk_stop_wr, i_wake_wr, i_wake_data} = {2'b01, 17'h2 << s[3:0]};
    chk({o_mcu_run, o_periph_run[s[3:0]]}, 0);
    step();
    i_wake_wr = 1'b0;
    chk({o_mcu_run, o_periph_run[s[3:0]]}, 2'b01);
    i_periph_irq[s[7:4]] = 1'b1;
    step();
    i_periph_irq = '0;
    chk(o_mcu_run, 1);
    for (k = 0; k < 4; k++)
    begin
      i_rbspc_jtag_emu.pick(k[1:0]);
      chk({o_scan_mode, o_ir_len_total}, {k[1:0], exp_len(k[1:0])});
    end
    chk({o_ir_len_mcu, o_ir_len_dsp, o_ir_len_chip, o_instr_32bit, o_big_endian}, {15'h1108, st});
    tally_and_finish();
  end
endmodule
bind rbspc_top rbspc_monitor #(.NUM_PERIPH(NUM_PERIPH)) i_rbspc_monitor (.*);

// ### core/rbspc_edge_capture.sv
// Module: synchronised capture of pin levels on the rising edge of a trigger
`timescale 1ns/1ns
module rbspc_edge_capture #(
  parameter int   W         = 2,
  parameter logic TRIG_IDLE = 1'b0   // Trigger history in reset; match the pin's idle level
)
(
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst_n,
  input  wire logic         i_trig,
  input  wire logic [W-1:0] i_pins,
  output logic      [W-1:0] o_value
);

  logic [W-1:0] pins_meta_q;
  logic [W-1:0] pins_sync_q;
  logic         trig_meta_q;
  logic         trig_sync_q;
  logic         trig_last_q;

  // Width check
  initial
  begin
    if (W < 1)
      $error("rbspc_edge_capture: W must be at least 1");
  end

  // Two-stage synchronisers; the first stages feed only the second
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pins_meta_q <= '0;
      pins_sync_q <= '0;
      trig_meta_q <= TRIG_IDLE;
      trig_sync_q <= TRIG_IDLE;
    end
    else
    begin
      pins_meta_q <= i_pins;
      pins_sync_q <= pins_meta_q;
      trig_meta_q <= i_trig;
      trig_sync_q <= trig_meta_q;
    end
  end

  // Edge history of the synchronised trigger
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      trig_last_q <= TRIG_IDLE;
    else
      trig_last_q <= trig_sync_q;
  end

  // Value held until the next rising edge of the trigger
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_value <= '0;
    else if (trig_sync_q && !trig_last_q)
      o_value <= pins_sync_q;
  end

endmodule

// ### core/rbspc_pkg.sv
// Package: constants and types of the reset, boot strap and power control block
package rbspc_pkg;

  // ----------------------------------------------------------------------
  // Subsystem reset control register on the MCU memory port
  // ----------------------------------------------------------------------
  localparam logic [31:0] RST_CTRL_ADDR    = 32'h0FFF2F10;
  localparam int          RST_DSP_BIT      = 0;
  localparam int          RST_EXT_BIT      = 1;
  localparam logic [1:0]  RST_CTRL_RESET   = 2'h1;   // DSP held, external released
  localparam logic [31:0] RDATA_NONE       = 32'h00000000;

  // ----------------------------------------------------------------------
  // Reset vectors and DSP memory map
  // ----------------------------------------------------------------------
  localparam logic [31:0] MCU_RESET_VECTOR = 32'h00000000;
  localparam logic [15:0] DSP_RESET_VECTOR = 16'hFF80;
  localparam logic [15:0] OVL_PROG_BASE    = 16'hF800;
  localparam logic [15:0] OVL_DATA_BASE    = 16'h3800;
  localparam logic [15:0] OVL_DATA_LAST    = 16'h3FFF;

  // ----------------------------------------------------------------------
  // DSP configuration register layout
  // ----------------------------------------------------------------------
  localparam int          DSPCFG_W         = 16;
  localparam int          DSPCFG_EXT_BIT   = 15;
  localparam int          DSPCFG_OVL_BIT   = 14;
  localparam int          DSPCFG_PLL_W     = 14;
  localparam logic [15:0] DSPCFG_RESET     = 16'h0000;

  // ----------------------------------------------------------------------
  // MCU clock module and timing
  // ----------------------------------------------------------------------
  localparam int          PD_DIV_W         = 10;
  localparam logic [9:0]  PD_DIV_MIN       = 10'h200;
  localparam logic [9:0]  PD_CNT_ONE       = 10'h001;
  localparam int          DIV_W            = 2;
  localparam int          WDOG_RST_CYCLES  = 4;
  localparam int          WDOG_CNT_W       = 8;

  // ----------------------------------------------------------------------
  // Scan chain instruction register lengths
  // ----------------------------------------------------------------------
  localparam logic [4:0]  IR_LEN_MCU       = 5'h04;
  localparam logic [4:0]  IR_LEN_DSP       = 5'h08;
  localparam logic [4:0]  IR_LEN_CHIP      = 5'h08;
  localparam logic [4:0]  IR_LEN_NONE      = 5'h00;

  // ----------------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CLK_PLL   = 2'b00,
    CLK_DIV   = 2'b01,
    CLK_PDOWN = 2'b10,
    CLK_RSVD  = 2'b11
  } rbspc_clk_mode_t;

  typedef enum logic [1:0] {
    SCAN_MCU   = 2'b00,
    SCAN_DSP   = 2'b01,
    SCAN_RSVD  = 2'b10,
    SCAN_CHAIN = 2'b11
  } rbspc_scan_mode_t;

  typedef enum logic [1:0] {
    BOOT_SHADOW_RAM = 2'b00,
    BOOT_PROG_RAM   = 2'b01,
    BOOT_EXTERNAL   = 2'b10
  } rbspc_boot_mem_t;

endpackage

// ### core/rbspc_top.sv
// Module: reset distribution, boot straps, DSP boot and MCU power control
`timescale 1ns/1ns
module rbspc_top
  import rbspc_pkg::*;
#(
  parameter int                 NUM_PERIPH      = 16,
  parameter int                 WDOG_CYCLES     = rbspc_pkg::WDOG_RST_CYCLES,
  parameter int                 BOOT_REGION_W   = 24,
  parameter logic [13:0]        MCU_PLL_DEFAULT = 14'h0000
)
(
  input  wire logic                              i_clk_sys,
  input  wire logic                              i_rst_n,
  input  wire logic                              i_test_rst_n,
  input  wire logic                              i_instr_width_strap,
  input  wire logic                              i_endian_strap,
  input  wire logic                              i_scan_sel_lo,
  input  wire logic                              i_scan_sel_hi,
  input  wire logic                              i_wdog_rst_cmd,
  input  wire logic                              i_mcu_sel,
  input  wire logic                              i_mcu_we,
  input  wire logic [31:0]                       i_mcu_addr,
  input  wire logic [31:0]                       i_mcu_wdata,
  output logic      [31:0]                       o_mcu_rdata,
  output logic                                   o_mcu_ack,
  input  wire logic                              i_dsp_cfg_wr,
  input  wire logic [rbspc_pkg::DSPCFG_W-1:0]    i_dsp_cfg_data,
  input  wire logic                              i_periph_rst_wr,
  input  wire logic [NUM_PERIPH-1:0]             i_periph_rst_data,
  input  wire logic                              i_clk_stop_wr,
  input  wire logic [NUM_PERIPH:0]               i_clk_stop_data,
  input  wire logic                              i_wake_wr,
  input  wire logic [NUM_PERIPH:0]               i_wake_data,
  input  wire logic [NUM_PERIPH-1:0]             i_periph_irq,
  input  wire rbspc_pkg::rbspc_clk_mode_t        i_pll_mode_cfg,
  input  wire logic [rbspc_pkg::DIV_W-1:0]       i_div_ratio,
  input  wire logic [rbspc_pkg::PD_DIV_W-1:0]    i_pd_divisor,
  input  wire logic [15:0]                       i_dsp_prog_addr,
  output logic                                   o_mcu_rst_n,
  output logic                                   o_dsp_rst_n,
  output logic                                   o_ext_rst_n,
  output logic      [31:0]                       o_mcu_reset_vector,
  output logic                                   o_boot_chip_select,
  output logic      [15:0]                       o_dsp_reset_vector,
  output logic      [NUM_PERIPH-1:0]             o_periph_rst_n,
  output logic                                   o_instr_32bit,
  output logic                                   o_big_endian,
  output rbspc_pkg::rbspc_scan_mode_t            o_scan_mode,
  output logic      [4:0]                        o_ir_len_mcu,
  output logic      [4:0]                        o_ir_len_dsp,
  output logic      [4:0]                        o_ir_len_chip,
  output logic      [4:0]                        o_ir_len_total,
  output rbspc_pkg::rbspc_boot_mem_t             o_dsp_boot_mem,
  output logic                                   o_overlay_en,
  output logic                                   o_overlay_hit,
  output logic      [15:0]                       o_overlay_data_addr,
  output logic      [rbspc_pkg::DSPCFG_PLL_W-1:0] o_dsp_pll_default,
  output logic      [13:0]                       o_mcu_pll_default,
  output logic                                   o_mcu_clk_tick,
  output logic                                   o_mcu_run,
  output logic      [NUM_PERIPH-1:0]             o_periph_run
);

  import rbspc_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [WDOG_CNT_W-1:0] wdog_cnt_q;
  logic                  mcu_sub_rst;
  logic [1:0]            rst_ctrl_q;
  logic                  ctrl_hit;
  logic [DSPCFG_W-1:0]   dsp_cfg_q;
  logic [NUM_PERIPH-1:0] periph_rst_q;
  logic [NUM_PERIPH:0]   run_q;
  logic [PD_DIV_W-1:0]   clk_cnt_q;
  logic [PD_DIV_W-1:0]   clk_limit;
  logic                  clk_stop;
  logic [1:0]            reset_straps;
  logic [1:0]            scan_straps;

  // Parameter checks
  initial
  begin
    if (NUM_PERIPH < 1 || NUM_PERIPH > 31)
      $error("rbspc_top: NUM_PERIPH must be 1 to 31");
    if (WDOG_CYCLES < 1 || WDOG_CYCLES > 255)
      $error("rbspc_top: WDOG_CYCLES must be 1 to 255");
    if (BOOT_REGION_W < 1 || BOOT_REGION_W > 31)
      $error("rbspc_top: BOOT_REGION_W must be 1 to 31");
  end

  // ----------------------------------------------------------------------
  // Reset distribution
  // ----------------------------------------------------------------------

  // Watchdog command stretched so the MCU side sees a clean reset
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      wdog_cnt_q <= '0;
    else if (i_wdog_rst_cmd)
      wdog_cnt_q <= WDOG_CNT_W'(WDOG_CYCLES);
    else if (wdog_cnt_q != '0)
      wdog_cnt_q <= wdog_cnt_q - 1'b1;
  end

  assign mcu_sub_rst = i_wdog_rst_cmd || (wdog_cnt_q != '0);

  // Reset outputs assert at once with the master reset, release on the clock
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_mcu_rst_n <= 1'b0;
      o_dsp_rst_n <= 1'b0;
      o_ext_rst_n <= 1'b0;
    end
    else
    begin
      o_mcu_rst_n <= !mcu_sub_rst;
      o_dsp_rst_n <= !rst_ctrl_q[RST_DSP_BIT];
      o_ext_rst_n <= !rst_ctrl_q[RST_EXT_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // MCU memory port: subsystem reset control register
  // ----------------------------------------------------------------------
  assign ctrl_hit = (i_mcu_addr == RST_CTRL_ADDR);

  // Only the master reset loads RST_CTRL_RESET into it; the watchdog must not touch the DSP
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rst_ctrl_q <= RST_CTRL_RESET;
    else if (i_mcu_sel && i_mcu_we && ctrl_hit)
      rst_ctrl_q <= i_mcu_wdata[1:0];
  end

  // Read data and acknowledge one cycle after the request; others read zero
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_mcu_rdata <= RDATA_NONE;
      o_mcu_ack   <= 1'b0;
    end
    else
    begin
      o_mcu_ack <= i_mcu_sel;
      if (i_mcu_sel && !i_mcu_we && ctrl_hit)
        o_mcu_rdata <= {30'h00000000, rst_ctrl_q};
      else
        o_mcu_rdata <= RDATA_NONE;
    end
  end

  // ----------------------------------------------------------------------
  // Reset vectors and boot fetch
  // ----------------------------------------------------------------------
  // Boot chip select covers the low region holding the vector
  assign o_mcu_reset_vector = MCU_RESET_VECTOR;
  assign o_boot_chip_select = (i_mcu_addr[31:BOOT_REGION_W] == '0);
  assign o_dsp_reset_vector = DSP_RESET_VECTOR;

  // ----------------------------------------------------------------------
  // Peripheral reset register
  // ----------------------------------------------------------------------

  // Set bit keeps a peripheral active; any MCU reset sets all
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      periph_rst_q <= '1;
    else if (mcu_sub_rst)
      periph_rst_q <= '1;
    else if (i_periph_rst_wr)
      periph_rst_q <= i_periph_rst_data;
  end

  assign o_periph_rst_n = periph_rst_q & {NUM_PERIPH{o_mcu_rst_n}};

  // ----------------------------------------------------------------------
  // Boot straps
  // ----------------------------------------------------------------------

  // Master release: trigger held high, captured once the reset lets go
  rbspc_edge_capture #(
    .W         (2)
  ) u_reset_straps (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_trig    (1'b1),
    .i_pins    ({i_endian_strap, i_instr_width_strap}),
    .o_value   (reset_straps)
  );

  assign o_instr_32bit = reset_straps[0];
  assign o_big_endian  = reset_straps[1];

  // Test reset pin is asynchronous; its release edge is found after syncing.
  // Idle-high history so a master reset release is not taken as a test reset rise
  rbspc_edge_capture #(
    .W         (2),
    .TRIG_IDLE (1'b1)
  ) u_scan_straps (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_trig    (i_test_rst_n),
    .i_pins    ({i_scan_sel_lo, i_scan_sel_hi}),
    .o_value   (scan_straps)
  );

  assign o_scan_mode = rbspc_scan_mode_t'(scan_straps);

  // ----------------------------------------------------------------------
  // Scan chain instruction lengths
  // ----------------------------------------------------------------------
  assign o_ir_len_mcu  = IR_LEN_MCU;
  assign o_ir_len_dsp  = IR_LEN_DSP;
  assign o_ir_len_chip = IR_LEN_CHIP;

  // Total length lets a debugger plan bypass codes for the chain
  always_comb
  begin
    case (o_scan_mode)
      SCAN_MCU:   o_ir_len_total = IR_LEN_MCU;
      SCAN_DSP:   o_ir_len_total = IR_LEN_DSP;
      SCAN_CHAIN: o_ir_len_total = IR_LEN_MCU + IR_LEN_DSP + IR_LEN_CHIP;
      default:    o_ir_len_total = IR_LEN_NONE;
    endcase
  end

  // ----------------------------------------------------------------------
  // DSP configuration: boot bits and PLL defaults
  // ----------------------------------------------------------------------

  // Written by MCU software while the DSP is still held
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      dsp_cfg_q <= DSPCFG_RESET;
    else if (i_dsp_cfg_wr)
      dsp_cfg_q <= i_dsp_cfg_data;
  end

  assign o_dsp_pll_default = dsp_cfg_q[DSPCFG_PLL_W-1:0];
  assign o_mcu_pll_default = MCU_PLL_DEFAULT;

  // Boot memory choice from the two boot bits
  always_comb
  begin
    case ({dsp_cfg_q[DSPCFG_EXT_BIT], dsp_cfg_q[DSPCFG_OVL_BIT]})
      2'b01:   o_dsp_boot_mem = BOOT_PROG_RAM;
      2'b11:   o_dsp_boot_mem = BOOT_EXTERNAL;
      default: o_dsp_boot_mem = BOOT_SHADOW_RAM;
    endcase
  end

  // Overlay window decode; translation keeps the low bits of the offset
  assign o_overlay_en        = !dsp_cfg_q[DSPCFG_OVL_BIT];
  assign o_overlay_hit       = o_overlay_en && (i_dsp_prog_addr >= OVL_PROG_BASE);
  assign o_overlay_data_addr = 16'(i_dsp_prog_addr - OVL_PROG_BASE + OVL_DATA_BASE);

  // ----------------------------------------------------------------------
  // MCU clock module
  // ----------------------------------------------------------------------

  // Divide limit per mode; low power-down divisors mean no clock at all
  always_comb
  begin
    clk_stop  = 1'b0;
    clk_limit = PD_CNT_ONE;
    case (i_pll_mode_cfg)
      CLK_PLL:
        clk_limit = PD_CNT_ONE;
      CLK_DIV:
        clk_limit = PD_DIV_W'(i_div_ratio) + PD_CNT_ONE;
      CLK_PDOWN:
      begin
        clk_limit = i_pd_divisor;
        clk_stop  = (i_pd_divisor < PD_DIV_MIN);
      end
      default:
        clk_stop  = 1'b1;
    endcase
  end

  // Tick once per divide period; a stopped MCU gets no ticks
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      clk_cnt_q      <= '0;
      o_mcu_clk_tick <= 1'b0;
    end
    else if (clk_stop)
    begin
      clk_cnt_q      <= '0;
      o_mcu_clk_tick <= 1'b0;
    end
    else if (clk_cnt_q + PD_CNT_ONE >= clk_limit)
    begin
      clk_cnt_q      <= '0;
      o_mcu_clk_tick <= run_q[0];
    end
    else
    begin
      clk_cnt_q      <= clk_cnt_q + PD_CNT_ONE;
      o_mcu_clk_tick <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Shutdown and wake
  // ----------------------------------------------------------------------

  // Bit 0 is the MCU, bits above the peripherals; wake beats stop
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      run_q <= '1;
    else if (mcu_sub_rst)
      run_q <= '1;
    else
    begin
      for (int k = 0; k <= NUM_PERIPH; k++)
      begin
        if (i_wake_wr && i_wake_data[k])
          run_q[k] <= 1'b1;
        else if (k == 0 && (|i_periph_irq))
          run_q[k] <= 1'b1;
        else if (i_clk_stop_wr && i_clk_stop_data[k])
          run_q[k] <= 1'b0;
      end
    end
  end

  assign o_mcu_run    = run_q[0];
  assign o_periph_run = run_q[NUM_PERIPH:1];

endmodule
